// File: logic/gpio_defines.vh
// register map, reset values and pin indices for the two-port i/o block
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH
`define ADDR_PORT0_DATA     8'h80
`define ADDR_PORT1_DATA     8'h90
`define ADDR_PORT0_DRIVE    8'h93
`define ADDR_PORT0_DIR      8'h94
`define ADDR_PORT0_FSEL     8'h95
`define ADDR_PORT1_DIR      8'h96
`define ADDR_PORT1_FSEL     8'h97
`define RST_PORT0_DATA      8'hff
`define RST_PORT1_DATA      4'hf
`define RST_PORT0_DRIVE     8'h00
`define RST_PORT0_DIR       8'hff
`define RST_PORT0_FSEL      8'h00
`define RST_PORT1_DIR       4'h4
`define RST_PORT1_FSEL      4'h0
`define SPI_ROUTE_BOOT      2'h1
`define P1_SCK              0
`define P1_MOSI             1
`define P1_MISO             2
`define P1_CSN              3
`define PORT0_FUNCTION_SELECT_OUT_MASK     8'h85
`define P0_UART_RX          1
`define P0_IRQ_A            3
`define P0_IRQ_B            4
`define P0_TIMER_A          5
`define P0_TIMER_B          6
`define P0_ODD_MASK         8'haa
`endif

// File: logic/port_zero_mux.v
// port zero pin function and direction mux
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.vh"
module port_zero_mux (
    input  wire [7:0] fsel,
    input  wire [7:0] dir,
    input  wire [7:0] latch,
    input  wire [7:0] alt_out,
    output reg  [7:0] out_val,
    output reg  [7:0] out_en
);
    // pins whose alternate function drives the pin outward
    localparam [7:0] alt_drives_out = `PORT0_FUNCTION_SELECT_OUT_MASK;
    integer i;
    always @* begin
        out_val = 8'h00;
        out_en  = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (fsel[i]) begin
                out_val[i] = alt_out[i];
                if (i == `P0_UART_RX)
                    out_en[i] = ~dir[i];
                else
                    out_en[i] = alt_drives_out[i];
            end else begin
                out_val[i] = latch[i];
                out_en[i]  = ~dir[i];
            end
        end
    end
endmodule // port_zero_mux
`default_nettype wire

// File: logic/port_one_mux.v
// port one pin function and direction mux
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.vh"
module port_one_mux (
    input  wire [1:0] spi_route,
    input  wire [3:0] fsel,
    input  wire [3:0] dir,
    input  wire [3:0] latch,
    input  wire       spi_sck,
    input  wire       spi_mosi,
    output reg  [3:0] out_val,
    output reg  [3:0] out_en
);
    always @* begin
        out_val = latch;
        out_en  = ~dir;
        out_en[`P1_MISO] = 1'b0;
        if (spi_route == `SPI_ROUTE_BOOT) begin
            out_val[`P1_SCK]  = spi_sck;
            out_val[`P1_MOSI] = spi_mosi;
            out_en[`P1_SCK]   = 1'b1;
            out_en[`P1_MOSI]  = 1'b1;
            out_en[`P1_CSN]   = 1'b1;
        end else if (fsel[`P1_SCK]) begin
            out_en[`P1_SCK] = 1'b0;
        end
    end
endmodule // port_one_mux
`default_nettype wire

// File: logic/dual_port_gpio.v
// two-port gpio with alternate function mux and sfr access
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.vh"
module dual_port_gpio (
    input  wire       core_clk,
    input  wire       nrst,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    input  wire [1:0] spi_route,
    input  wire       spi_sck,
    input  wire       spi_mosi,
    output reg        spi_miso,
    input  wire       general_timer_output,
    input  wire       uart_txd,
    input  wire       pwm_out,
    output reg        uart_rxd,
    output reg        external_irq_a_n,
    output reg        external_irq_b_n,
    output reg        timer_a_input,
    output reg        timer_b_input,
    output reg        timer_c_input,
    input  wire [7:0] port_zero_in,
    output reg  [7:0] port_zero_out,
    output reg  [7:0] port_zero_oe,
    output reg  [7:0] port_zero_source_hi,
    output reg  [7:0] port_zero_sink_hi,
    input  wire [3:0] port_one_in,
    output reg  [3:0] port_one_out,
    output reg  [3:0] port_one_oe
);
    reg  [7:0] p0_latch_r;
    reg  [3:0] p1_latch_r;
    reg  [7:0] p0_drive_r;
    reg  [7:0] port0_direction_r;
    reg  [7:0] p0_fsel_r;
    reg  [3:0] port1_direction_r;
    reg  [3:0] p1_fsel_r;
    reg  [7:0] rdata_nxt;
    wire [7:0] p0_val;
    wire [7:0] p0_en;
    wire [3:0] p1_val;
    wire [3:0] p1_en;
    wire [7:0] alt_out;
    wire [7:0] drive_on;

    assign alt_out = {pwm_out, 4'h0, uart_txd, 1'b0, general_timer_output};
    // active-low enable per register table
    assign drive_on = ~p0_drive_r;

    // register writes; configuration holds until written
    always @(posedge core_clk) begin
        if (!nrst) begin
            p0_latch_r <= `RST_PORT0_DATA;
            p1_latch_r <= `RST_PORT1_DATA;
            p0_drive_r <= `RST_PORT0_DRIVE;
            port0_direction_r   <= `RST_PORT0_DIR;
            p0_fsel_r  <= `RST_PORT0_FSEL;
            port1_direction_r   <= `RST_PORT1_DIR;
            p1_fsel_r  <= `RST_PORT1_FSEL;
        end else if (sfr_wr) begin
            case (sfr_addr)
                `ADDR_PORT0_DATA:  p0_latch_r <= sfr_wdata;
                `ADDR_PORT1_DATA:  p1_latch_r <= sfr_wdata[3:0];
                `ADDR_PORT0_DRIVE: p0_drive_r <= sfr_wdata;
                `ADDR_PORT0_DIR:   port0_direction_r   <= sfr_wdata;
                `ADDR_PORT0_FSEL:  p0_fsel_r  <= sfr_wdata;
                `ADDR_PORT1_DIR:   port1_direction_r   <= sfr_wdata[3:0];
                `ADDR_PORT1_FSEL:  p1_fsel_r  <= sfr_wdata[3:0];
                default: ;
            endcase
        end
    end

    // read mux: data registers return pin levels
    always @* begin
        case (sfr_addr)
            `ADDR_PORT0_DATA:  rdata_nxt = port_zero_in;
            `ADDR_PORT1_DATA:  rdata_nxt = {4'h0, port_one_in};
            `ADDR_PORT0_DRIVE: rdata_nxt = p0_drive_r;
            `ADDR_PORT0_DIR:   rdata_nxt = port0_direction_r;
            `ADDR_PORT0_FSEL:  rdata_nxt = p0_fsel_r;
            `ADDR_PORT1_DIR:   rdata_nxt = {4'h0, port1_direction_r};
            `ADDR_PORT1_FSEL:  rdata_nxt = {4'h0, p1_fsel_r};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    port_zero_mux u_p0 (
        .fsel    (p0_fsel_r),
        .dir     (port0_direction_r),
        .latch   (p0_latch_r),
        .alt_out (alt_out),
        .out_val (p0_val),
        .out_en  (p0_en)
    );

    port_one_mux u_p1 (
        .spi_route (spi_route),
        .fsel      (p1_fsel_r),
        .dir       (port1_direction_r),
        .latch     (p1_latch_r),
        .spi_sck   (spi_sck),
        .spi_mosi  (spi_mosi),
        .out_val   (p1_val),
        .out_en    (p1_en)
    );

    // registered pin and peripheral outputs
    always @(posedge core_clk) begin
        if (!nrst) begin
            sfr_rdata           <= 8'h00;
            port_zero_out       <= `RST_PORT0_DATA;
            port_zero_oe        <= ~`RST_PORT0_DIR;
            // high drive shows the reset register value so release changes nothing
            port_zero_source_hi <= ~`RST_PORT0_DRIVE & `P0_ODD_MASK;
            port_zero_sink_hi   <= ~`RST_PORT0_DRIVE & ~`P0_ODD_MASK;
            port_one_out        <= `RST_PORT1_DATA;
            port_one_oe         <= ~`RST_PORT1_DIR;
            spi_miso            <= 1'b0;
            uart_rxd            <= 1'b1;
            external_irq_a_n    <= 1'b1;
            external_irq_b_n    <= 1'b1;
            timer_a_input       <= 1'b0;
            timer_b_input       <= 1'b0;
            timer_c_input       <= 1'b0;
        end else begin
            sfr_rdata           <= rdata_nxt;
            port_zero_out       <= p0_val;
            port_zero_oe        <= p0_en;
            port_zero_source_hi <= drive_on & `P0_ODD_MASK;
            port_zero_sink_hi   <= drive_on & ~`P0_ODD_MASK;
            port_one_out        <= p1_val;
            port_one_oe         <= p1_en;
            spi_miso            <= port_one_in[`P1_MISO];
            uart_rxd            <= port_zero_in[`P0_UART_RX] | ~p0_fsel_r[`P0_UART_RX];
            external_irq_a_n    <= port_zero_in[`P0_IRQ_A] | ~p0_fsel_r[`P0_IRQ_A];
            external_irq_b_n    <= port_zero_in[`P0_IRQ_B] | ~p0_fsel_r[`P0_IRQ_B];
            timer_a_input       <= port_zero_in[`P0_TIMER_A] & p0_fsel_r[`P0_TIMER_A];
            timer_b_input       <= port_zero_in[`P0_TIMER_B] & p0_fsel_r[`P0_TIMER_B];
            timer_c_input       <= port_one_in[`P1_SCK] & p1_fsel_r[`P1_SCK]
                                   & (spi_route != `SPI_ROUTE_BOOT);
        end
    end
endmodule // dual_port_gpio
`default_nettype wire

// File: dv/gpio_pins_model.sv
// outside world at the pins: block level where enabled, else outside level
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
    input wire logic [7:0] z_lvl,
    input wire logic [7:0] z_en,
    input wire logic [7:0] z_ext,
    input wire logic [3:0] o_lvl,
    input wire logic [3:0] o_en,
    input wire logic [3:0] o_ext,
    output logic [7:0]     z_pin,
    output logic [3:0]     o_pin
);
    assign z_pin = (z_en & z_lvl) | (~z_en & z_ext);
    // bit 3 feeds the boot memory select; other slaves sit on port zero pins
    assign o_pin = (o_en & o_lvl) | (~o_en & o_ext);
endmodule // gpio_pins_model
`default_nettype wire

// File: dv/dual_port_gpio_asserts.sv
// assertions on the gpio block ports
`timescale 1ns/1ps
`default_nettype none
module gpio_checker (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       sfr_wr,
    input wire logic [1:0] spi_route,
    input wire logic       external_irq_a_n,
    input wire logic [7:0] port_zero_oe,
    input wire logic [7:0] port_zero_source_hi,
    input wire logic [3:0] port_one_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    chk_rst_zero: assert property (disable iff (1'b0) !nrst |=> port_zero_oe == 8'h00)
        else $error("port zero drives in reset");
    chk_rst_one: assert property (disable iff (1'b0) !nrst |=> port_one_oe == 4'hb)
        else $error("port one not spi in reset");
    chk_rst_drive: assert property (disable iff (1'b0) !nrst |=> port_zero_source_hi == 8'haa)
        else $error("drive reset wrong");
    chk_cfg_hold: assert property (!sfr_wr |-> ##2 $stable(port_zero_oe))
        else $error("port zero changed unwritten");
    chk_miso_in: assert property (!port_one_oe[2])
        else $error("data in pin driven");
    chk_spi_dir: assert property (spi_route == 2'h1 |=> port_one_oe == 4'hb)
        else $error("spi directions wrong");
    chk_irq_gate: assert property (port_zero_oe[3] |-> external_irq_a_n)
        else $error("irq passed without select");
    chk_odd_source: assert property ((port_zero_source_hi & 8'h55) == 8'h00)
        else $error("even pin sources");
endmodule // gpio_checker
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the two-port gpio block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, sck = 1'b1, mosi = 1'b0;
    logic [1:0] route = 2'h1;
    logic [3:0] o_in, o_out, o_oe;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, z_in, z_out, z_oe, src, snk;
    logic miso, rxd, ia, ib, ta, tb, tc;
    int num_errors = 0, total_checks = 0;
    dual_port_gpio dual_port_gpio_inst (.core_clk(core_clk), .nrst(nrst), .sfr_addr(addr),
        .sfr_wr(wr_en), .sfr_wdata(wdata), .sfr_rdata(rdata), .spi_route(route), .spi_sck(sck),
        .spi_mosi(mosi), .spi_miso(miso), .general_timer_output(1'b1), .uart_txd(1'b0),
        .pwm_out(1'b1), .uart_rxd(rxd), .external_irq_a_n(ia), .external_irq_b_n(ib),
        .timer_a_input(ta), .timer_b_input(tb), .timer_c_input(tc), .port_zero_in(z_in),
        .port_zero_out(z_out), .port_zero_oe(z_oe), .port_zero_source_hi(src),
        .port_zero_sink_hi(snk), .port_one_in(o_in), .port_one_out(o_out), .port_one_oe(o_oe));
    gpio_pins_model gpio_pins_model_inst (.z_lvl(z_out), .z_en(z_oe), .z_ext(8'h22),
        .o_lvl(o_out), .o_en(o_oe), .o_ext(4'h5), .z_pin(z_in), .o_pin(o_in));
    initial forever #4 core_clk = ~core_clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        tk(2);
        ck(rdata, exp);
    endtask
    initial begin
        repeat (1000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
    task automatic test_reset();
        ck(z_oe, 8'h00);
        ck({4'h0, o_oe}, 8'h0b);
        ck({5'h0, ia, ib, ta}, 8'h06);
        rd(8'h93, 8'h00);
        rd(8'h81, 8'h00);
        rd(8'h80, 8'h22);
        $display("test reset done");
    endtask
    task automatic test_port_zero();
        wr(8'h94, 8'h00);
        wr(8'h93, 8'h0f);
        tk(3);
        ck(z_oe, 8'hff);
        ck(z_out, 8'hff);
        ck(src, 8'ha0);
        ck(snk, 8'h50);
        wr(8'h95, 8'hff);
        tk(3);
        ck(z_oe, 8'h87);
        ck(z_out, 8'h81);
        ck({3'h0, rxd, ia, ib, ta, tb}, 8'h02);
        $display("test port zero done");
    endtask
    task automatic test_port_one();
        route <= 2'h0;
        wr(8'h97, 8'h0f);
        tk(3);
        ck({4'h0, o_oe}, 8'h0a);
        ck({7'h0, tc}, 8'h01);
        ck({7'h0, miso}, 8'h01);
        route <= 2'h1;
        sck <= 1'b0;
        mosi <= 1'b1;
        tk(3);
        ck({4'h0, o_oe}, 8'h0b);
        ck({4'h0, o_out}, 8'h0e);
        ck({7'h0, tc}, 8'h00);
        rd(8'h90, 8'h0e);
        $display("test port one done");
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        tk(1);
        test_reset();
        test_port_zero();
        test_port_one();
        print_verdict();
    end
endmodule // testbench
bind dual_port_gpio gpio_checker gpio_checker_inst (.core_clk(core_clk), .nrst(nrst),
    .sfr_wr(sfr_wr), .spi_route(spi_route), .external_irq_a_n(external_irq_a_n),
    .port_zero_oe(port_zero_oe), .port_zero_source_hi(port_zero_source_hi),
    .port_one_oe(port_one_oe));
`default_nettype wire
